// >>> pkg/eeprom_pkg.sv
package eeprom_pkg;

  // ==========================================================
  // command opcodes
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;
  localparam logic [7:0] OP_READ_ARRAY = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

  // ==========================================================
  // frame geometry
  localparam int OPC_LEN = 8;
  localparam int ADDR_LEN = 16;
  localparam int BYTE_LEN = 8;
  localparam logic [2:0] BYTE_MSB = 3'h7;
  localparam int ADDR_BITS_SMALL = 10;
  localparam int ADDR_BITS_LARGE = 11;

  // ==========================================================
  // status byte
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam int ST_PROTECT_PIN_ENABLE = 7;
  localparam logic [7:0] STATUS_WR_MASK = 8'h8c;
  localparam logic RST_BLOCK_GUARD = 1'b0;
  localparam logic RST_PROTECT_EN = 1'b0;

  typedef struct packed {
    logic protect_pin_enable;
    logic [2:0] zero;
    logic block_guard_hi;
    logic block_guard_lo;
    logic write_latch_bit;
    logic busy;
  } status_s;

  localparam status_s STATUS_RESET = 8'h00;

  // ==========================================================
  // timing
  localparam int MCLK_KHZ = 25000;
  localparam int TWC_NS = 5000;
  localparam int TWC_CYC = (TWC_NS * MCLK_KHZ + 999999) / 1000000;

  // array fill port
  typedef struct packed {
    logic en;
    logic [15:0] addr;
    logic [7:0] data;
  } fill_s;

endpackage : eeprom_pkg

// >>> hdl/eeprom_array.sv
`timescale 1ns/1ps

// ==========================================================
// byte array: written on mclk, read without a clock by the link side
module eeprom_array
  import eeprom_pkg::*;
#(
  parameter int ABITS = ADDR_BITS_SMALL
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [ABITS-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [ABITS-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [0:(1<<ABITS)-1];

  // fill only while no frame is open; the read port has no crossing
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : eeprom_array

// >>> hdl/spi_eeprom_core.sv
`timescale 1ns/1ps

module spi_eeprom_core
  import eeprom_pkg::*;
#(
  parameter int ABITS = ADDR_BITS_SMALL
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  input wire logic write_latch_bit,
  input wire fill_s fill,
  output logic busy,
  output logic block_guard_lo,
  output logic block_guard_hi,
  output logic protect_pin_enable
);

  // ==========================================================
  // elaboration check
  generate
    if (ABITS != ADDR_BITS_SMALL && ABITS != ADDR_BITS_LARGE) begin : g_bad_abits
      $error("ABITS must be 10 or 11");
    end
  endgenerate

  localparam int CW = $clog2(TWC_CYC + 1);
  localparam logic [CW-1:0] TWC_LOAD = CW'(TWC_CYC);
  localparam logic [4:0] OPC_LAST = 5'(OPC_LEN - 1);
  localparam logic [4:0] ADDR_LAST = 5'(ADDR_LEN - 1);
  localparam logic [4:0] BYTE_LAST = 5'(BYTE_LEN - 1);

  typedef enum logic [2:0] {
    S_OPC,
    S_ADDR,
    S_RDATA,
    S_SREAD,
    S_WDATA,
    S_IGNORE
  } link_state_e;

  // ==========================================================
  // link side declarations (sck domain, frame reset by cs_n, status copy and write capture reset by resetn)
  link_state_e state;
  link_state_e next_cmd_state;
  logic [4:0] cnt;
  logic [15:0] sh;
  logic [15:0] rx16;
  logic [ABITS-1:0] addr;
  logic [7:0] mem_byte;
  logic [7:0] wr_byte;
  logic wr_tog;
  status_s stat_s1;
  status_s stat_s2;
  logic [2:0] bit_sel;

  // ==========================================================
  // system side declarations (mclk domain)
  status_s stat_m;
  logic cs_s1;
  logic cs_s2;
  logic cs_prev;
  logic wp_s1;
  logic wp_s2;
  logic wp_prev;
  logic tog_s1;
  logic tog_s2;
  logic tog_prev;
  logic tog_edge;
  logic cs_rise;
  logic wp_fall;
  logic pending;
  logic pend_any;
  logic abort;
  logic hw_protect;
  logic [7:0] staged;
  logic [CW-1:0] wc_cnt;
  logic bp_lo;
  logic bp_hi;
  logic pen;
  logic start_write;

  assign rx16 = {sh[14:0], si};

  // ==========================================================
  // status synchroniser into the link domain
  // sck stops between frames, so the copy refreshes during the opcode
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      stat_s1 <= STATUS_RESET;
      stat_s2 <= STATUS_RESET;
    end else begin
      stat_s1 <= stat_m;
      stat_s2 <= stat_s1;
    end
  end

  // ==========================================================
  // opcode decode
  always_comb begin
    next_cmd_state = S_IGNORE;
    if (rx16[7:0] == OP_READ_STATUS) begin
      next_cmd_state = S_SREAD;
    end else if (stat_s2.busy) begin
      next_cmd_state = S_IGNORE;
    end else if (rx16[7:0] == OP_READ_ARRAY) begin
      next_cmd_state = S_ADDR;
    end else if (rx16[7:0] == OP_WRITE_STATUS) begin
      next_cmd_state = S_WDATA;
    end else begin
      next_cmd_state = S_IGNORE;
    end
  end

  // ==========================================================
  // input shifter, rising edge
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      sh <= 16'h0000;
    end else begin
      sh <= rx16;
    end
  end

  // ==========================================================
  // frame sequencer
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      state <= S_OPC;
      cnt <= 5'h00;
    end else begin
      unique case (state)
        S_OPC: begin
          if (cnt == OPC_LAST) begin
            cnt <= 5'h00;
            state <= next_cmd_state;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        S_ADDR: begin
          if (cnt == ADDR_LAST) begin
            cnt <= 5'h00;
            state <= S_RDATA;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        S_RDATA, S_SREAD: begin
          if (cnt == BYTE_LAST) begin
            cnt <= 5'h00;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        S_WDATA: begin
          if (cnt == BYTE_LAST) begin
            cnt <= 5'h00;
            state <= S_IGNORE;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        S_IGNORE: begin
          cnt <= cnt;
        end
      endcase
    end
  end

  // ==========================================================
  // address pointer
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      addr <= '0;
    end else if (state == S_ADDR && cnt == ADDR_LAST) begin
      addr <= rx16[ABITS-1:0];
    end else if (state == S_RDATA && cnt == BYTE_LAST) begin
      addr <= addr + 1'b1;
    end
  end

  // ==========================================================
  // status write capture; toggle survives the frame end on purpose
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      wr_byte <= 8'h00;
      wr_tog <= 1'b0;
    end else if (state == S_WDATA && cnt == BYTE_LAST) begin
      wr_byte <= rx16[7:0];
      wr_tog <= ~wr_tog;
    end
  end

  // ==========================================================
  // output shifter, falling edge
  assign bit_sel = BYTE_MSB - cnt[2:0];

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (state == S_RDATA) begin
      so <= mem_byte[bit_sel];
      so_oe <= 1'b1;
    end else if (state == S_SREAD) begin
      so <= stat_s2[bit_sel];
      so_oe <= 1'b1;
    end else begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end
  end

  // ==========================================================
  // array
  eeprom_array #(
    .ABITS(ABITS)
  ) u_array (
    .mclk(mclk),
    .wr_en(fill.en),
    .wr_addr(fill.addr[ABITS-1:0]),
    .wr_data(fill.data),
    .rd_addr(addr),
    .rd_data(mem_byte)
  );

  // ==========================================================
  // pin synchronisers into mclk
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_prev <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      wp_prev <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_prev <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_prev <= cs_s2;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
      wp_prev <= wp_s2;
      tog_s1 <= wr_tog;
      tog_s2 <= tog_s1;
      tog_prev <= tog_s2;
    end
  end

  assign tog_edge = tog_s2 ^ tog_prev;
  assign cs_rise = cs_s2 & ~cs_prev;
  assign wp_fall = ~wp_s2 & wp_prev;
  assign pend_any = pending | tog_edge;
  assign hw_protect = pen & ~wp_s2;
  assign start_write = cs_rise & pend_any & ~abort & write_latch_bit & ~hw_protect
    & ~busy;

  // ==========================================================
  // status write bookkeeping; a late toggle still counts at frame end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pending <= 1'b0;
      staged <= 8'h00;
    end else if (cs_rise) begin
      pending <= 1'b0;
      if (start_write) begin
        staged <= wr_byte;
      end
    end else if (tog_edge) begin
      pending <= 1'b1;
    end
  end

  // abort only matters while a frame is open
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      abort <= 1'b0;
    end else if (cs_rise) begin
      abort <= 1'b0;
    end else if (!cs_s2 && wp_fall && pen) begin
      abort <= 1'b1;
    end
  end

  // ==========================================================
  // internal write cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy <= 1'b0;
      wc_cnt <= '0;
    end else if (start_write) begin
      busy <= 1'b1;
      wc_cnt <= TWC_LOAD;
    end else if (busy) begin
      if (wc_cnt == '0) begin
        busy <= 1'b0;
      end else begin
        wc_cnt <= wc_cnt - 1'b1;
      end
    end
  end

  // commit ignores the protect pin once the cycle runs
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bp_lo <= RST_BLOCK_GUARD;
      bp_hi <= RST_BLOCK_GUARD;
      pen <= RST_PROTECT_EN;
    end else if (busy && wc_cnt == '0) begin
      bp_lo <= staged[ST_BP_LO];
      bp_hi <= staged[ST_BP_HI];
      pen <= staged[ST_PROTECT_PIN_ENABLE];
    end
  end

  // ==========================================================
  // status image
  always_comb begin
    stat_m = STATUS_RESET;
    stat_m.busy = busy;
    stat_m.write_latch_bit = write_latch_bit;
    stat_m.block_guard_lo = bp_lo;
    stat_m.block_guard_hi = bp_hi;
    stat_m.protect_pin_enable = pen;
  end

  assign block_guard_lo = bp_lo;
  assign block_guard_hi = bp_hi;
  assign protect_pin_enable = pen;

endmodule : spi_eeprom_core

// >>> verif/eeprom_props.sv
`timescale 1ns/1ps
// ==========================================================
// port checks
module eeprom_props
  import eeprom_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic block_guard_lo,
  input wire logic block_guard_hi,
  input wire logic protect_pin_enable
);
  logic [7:0] bcnt;
  logic [7:0] opc;
  logic [7:0] bw;
  // frame bit count, cleared by chip select like the device
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bcnt <= 8'h00;
      opc <= 8'h00;
    end else begin
      bcnt <= (bcnt == 8'hff) ? bcnt : bcnt + 8'h01;
      if (bcnt < 8'h08) opc <= {opc[6:0], si};
    end
  end
  always_ff @(posedge mclk) begin
    bw <= busy ? bw + 8'h01 : 8'h00;
  end
  oe_released_a: assert property (@(posedge mclk) disable iff (!resetn)
    cs_n |-> !so_oe && !so) else $error("output driven outside frame");
  busy_len_a: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(busy) |-> bw == TWC_CYC + 1) else $error("busy length wrong");
  status_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !$fell(busy) |-> $stable({protect_pin_enable, block_guard_hi, block_guard_lo}))
    else $error("status changed outside commit");
  wp_block_a: assert property (@(posedge mclk) disable iff (!resetn)
    (protect_pin_enable && !wp_n) [*8] |-> !$rose(busy)) else $error("protected write ran");
  start_after_cs_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(busy) |-> cs_n && $past(cs_n) && $past(cs_n, 2)) else $error("write cycle in frame");
  oe_start_a: assert property (@(posedge sck) disable iff (cs_n)
    $rose(so_oe) |-> (bcnt == 8'h18 && opc == OP_READ_ARRAY)
    || (bcnt == 8'h08 && opc == OP_READ_STATUS)) else $error("output start wrong");
  oe_steady_a: assert property (@(posedge sck) disable iff (cs_n)
    bcnt > 8'h01 |-> !$fell(so_oe)) else $error("output dropped in frame");
  so_quiet_a: assert property (@(posedge sck) disable iff (cs_n)
    !so_oe |-> !so) else $error("data without enable");
endmodule : eeprom_props

bind spi_eeprom_core eeprom_props props_u (.mclk(mclk), .resetn(resetn), .sck(sck),
  .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy),
  .block_guard_lo(block_guard_lo), .block_guard_hi(block_guard_hi),
  .protect_pin_enable(protect_pin_enable));

// >>> verif/spi_host.sv
`timescale 1ns/1ps
// ==========================================================
// host model: one frame per call, clock still between frames
module spi_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic [7:0] rx;
  logic oe_seen;
  event got;
  // a real deselect edge at start, so frame logic and output never sit unknown
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    #1 cs_n = 1'b1;
  end
  task frame(input logic [31:0] tx, input int nhd, input int nrx, input logic cpol);
    int i;
    oe_seen = 1'b0;
    sck = cpol;
    #3;
    cs_n = 1'b0;
    for (i = 0; i < nhd + 8 * nrx; i++) begin
      sck = 1'b0;
      si = (i < nhd) ? tx[31 - i] : ~si;
      #3;
      oe_seen = oe_seen | so_oe;
      rx = {rx[6:0], so};
      sck = 1'b1;
      if (oe_seen && i >= nhd && (i - nhd) % 8 == 7) -> got;
      #3;
    end
    sck = cpol;
    #3;
    cs_n = 1'b1;
    si = ~si;
  endtask : frame
endmodule : spi_host

// >>> verif/spi_eeprom_read_and_status_write_tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench
module spi_eeprom_read_and_status_write_tb;
  import eeprom_pkg::*;
  logic mclk, resetn, sck, cs_n, si, wp_n, so, so_oe, write_latch_bit, busy, lo, hi, pe, cpol;
  fill_s fill;
  int fails, n_tests, seed, k;
  logic [7:0] st;
  logic [7:0] mem [0:1023];
  logic [7:0] exp_q [$];
  spi_eeprom_core #(.ABITS(10)) dut_u (.mclk(mclk), .resetn(resetn), .sck(sck), .cs_n(cs_n),
    .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .write_latch_bit(write_latch_bit),
    .fill(fill), .busy(busy), .block_guard_lo(lo), .block_guard_hi(hi),
    .protect_pin_enable(pe));
  spi_host host_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task check(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task end_sim;
    check("bytes left", 8'h00, 8'(exp_q.size()));
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  function automatic logic [7:0] sbyte(input logic b);
    return {st[7], 3'h0, st[3:2], write_latch_bit, b};
  endfunction : sbyte
  initial forever begin
    @(host_u.got);
    check("so byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, host_u.rx);
  end
  task rd_stat(input logic b);
    exp_q.push_back(sbyte(b));
    exp_q.push_back(sbyte(b));
    host_u.frame({OP_READ_STATUS, 24'h0}, 8, 2, cpol);
  endtask : rd_stat
  task rd_arr(input logic [15:0] a, input int n);
    for (k = 0; k < n; k++) exp_q.push_back(mem[10'(a + 16'(k))]);
    host_u.frame({OP_READ_ARRAY, a, 8'h00}, 24, n, cpol);
  endtask : rd_arr
  // no answer expected: one byte clocked to catch a stray output
  task quiet(input logic [7:0] op);
    host_u.frame({op, 24'h0}, 24, 1, cpol);
    check("no output", 8'h00, {7'h0, host_u.oe_seen});
  endtask : quiet
  // mode 1: protect pin pulses low in frame, 2: reads while busy, 3: pin falls after start
  task wr_stat(input logic [7:0] d, input logic ok, input int mode);
    logic seen;
    seen = 1'b0;
    fork
      host_u.frame({OP_WRITE_STATUS, d, 16'h0}, 16, 0, cpol);
      if (mode == 1) begin
        @(posedge mclk);
        #1 wp_n = 1'b0;
        // pin back high before frame end: only the abort can refuse
        @(posedge mclk);
        #1 wp_n = 1'b1;
      end
    join
    for (k = 0; k < 10 && !seen; k++) begin
      @(posedge mclk);
      seen = busy;
    end
    check("busy start", {7'h0, ok}, {7'h0, seen});
    if (mode == 2) begin
      rd_stat(1'b1);
      quiet(OP_READ_ARRAY);
    end
    if (mode == 3) #1 wp_n = 1'b0;
    for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge mclk);
    if (busy !== 1'b0) begin
      fails++;
      end_sim();
    end
    if (ok) st = d & STATUS_WR_MASK;
    check("status", sbyte(1'b0), {pe, 3'h0, hi, lo, write_latch_bit, busy});
    @(posedge mclk);
    #1 wp_n = 1'b1;
    $display("status write test mode %0d done", mode);
  endtask : wr_stat
  initial begin
    seed = 69477;
    fails = 0;
    n_tests = 0;
    cpol = 1'b0;
    st = 8'h00;
    resetn = 1'b1;
    wp_n = 1'b1;
    write_latch_bit = 1'b1;
    fill = '0;
    // a real falling edge for the link side flops that reset on it
    #1 resetn = 1'b0;
    repeat (16) @(posedge mclk);
    #1 resetn = 1'b1;
    for (k = 0; k < 1024; k++) begin
      mem[k] = 8'($random(seed));
      fill = {1'b1, 16'(k), mem[k]};
      @(posedge mclk);
      #1;
    end
    fill.en = 1'b0;
    rd_stat(1'b0);
    $display("reset status test done");
    repeat (2) begin
      rd_arr({6'($random(seed)), 10'h3fe}, 4);
      rd_arr(16'($random(seed)), 2);
      cpol = ~cpol;
    end
    $display("array read test done");
    quiet(OP_WRITE_ARRAY);
    quiet(OP_WRITE_DISABLE);
    quiet(OP_WRITE_ENABLE);
    quiet(8'($random(seed)) | 8'h08);
    $display("undefined opcode test done");
    wp_n = 1'b0;
    wr_stat(8'($random(seed)) & 8'h7f, 1'b1, 0);
    write_latch_bit = 1'b0;
    wr_stat(8'hff, 1'b0, 0);
    write_latch_bit = 1'b1;
    cpol = 1'b1;
    wr_stat(8'($random(seed)) | 8'h80, 1'b1, 2);
    wp_n = 1'b0;
    wr_stat(8'h00, 1'b0, 0);
    wr_stat(8'h80, 1'b0, 1);
    wr_stat(8'($random(seed)) | 8'h80, 1'b1, 3);
    rd_stat(1'b0);
    end_sim();
  end
endmodule : spi_eeprom_read_and_status_write_tb
